// file: src/ebcs_pkg.sv
// Package of constants and types for the external bus cycle sequencer
`default_nettype none
package ebcs_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int NUM_CS = 4;
    localparam int CS_W = 2;
    // Timing configuration field layout, one word per chip select
    localparam int CFG_W = 13;
    localparam int AB_POS = 0;   // 1 bit: 0 -> 1 cycle, 1 -> 2 cycles
    localparam int C_POS = 1;    // 2 bits: 0..3
    localparam int D_POS = 3;    // 1 bit: 0..1
    localparam int E_POS = 4;    // 5 bits: value+1 = 1..32
    localparam int F_POS = 9;    // 2 bits: 0..3
    localparam int WX_POS = 11;  // 2 bits: window change extension 0..3
    localparam logic [CFG_W-1:0] CFG_RESET = 13'h1_FFF;
    localparam logic [5:0] ONE_CYCLE = 6'h01;
    localparam logic [5:0] ZERO_CYCLE = 6'h00;
    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        EBCS_IDLE = 6'b00_0001,
        EBCS_ADDR = 6'b00_0010,
        EBCS_CMD  = 6'b00_0100,
        EBCS_DSET = 6'b00_1000,
        EBCS_ACC  = 6'b01_0000,
        EBCS_HOLD = 6'b10_0000
    } ebcs_state_t;
endpackage
`default_nettype wire

// file: src/ebcs_ready_sync.sv
// Ready input polarity and optional synchroniser stage
`default_nettype none
module ebcs_ready_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Configuration
    input wire logic ready_active_high_i,
    input wire logic ready_async_i,
    // Pin and result
    input wire logic ready_pin_i,
    output logic ready_o
);
    logic s1_reg, s1_next, s2_reg, s2_next;
    logic lvl;

    // Two flops for an asynchronous ready; s1 only feeds s2
    always_comb begin
        lvl = ready_pin_i ~^ ready_active_high_i;
        s1_next = lvl;
        s2_next = s1_reg;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
        end
    end

    // Async path goes through both flops, hence two cycles of extra ready latency
    assign ready_o = ready_async_i ? s2_reg : lvl;
endmodule
`default_nettype wire

// file: src/ebcs_sequencer.sv
// External bus cycle sequencer: five-phase access engine
`default_nettype none
module ebcs_sequencer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Chip select timing configuration
    input wire logic [ebcs_pkg::NUM_CS*ebcs_pkg::CFG_W-1:0]
        chip_select_timing_config_i,
    input wire logic multiplexed_bus_mode_i,
    input wire logic [ebcs_pkg::NUM_CS-1:0] ready_enable_i,
    input wire logic ready_active_high_i,
    input wire logic ready_async_i,
    // Request side
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_write_i,
    input wire logic [ebcs_pkg::CS_W-1:0] req_cs_i,
    input wire logic [ebcs_pkg::ADDR_W-1:0] req_addr_i,
    input wire logic [ebcs_pkg::DATA_W-1:0] req_wdata_i,
    input wire logic req_upper_i,
    output logic rdata_valid_o,
    output logic [ebcs_pkg::DATA_W-1:0] rdata_o,
    output logic busy_o,
    // External bus pins
    output logic [ebcs_pkg::ADDR_W-1:0] separate_bus_mode_addr_bus_o,
    input wire logic [ebcs_pkg::DATA_W-1:0] separate_bus_mode_data_bus_i,
    output logic [ebcs_pkg::DATA_W-1:0] separate_bus_mode_data_bus_o,
    output logic separate_bus_mode_data_bus_oe_n_o,
    input wire logic [ebcs_pkg::DATA_W-1:0] shared_addr_data_bus_i,
    output logic [ebcs_pkg::DATA_W-1:0] shared_addr_data_bus_o,
    output logic shared_addr_data_bus_oe_n_o,
    output logic addr_latch_o,
    output logic read_n_o,
    output logic write_n_o,
    output logic upper_byte_enable_n_o,
    output logic [ebcs_pkg::NUM_CS-1:0] chip_select_n_o,
    input wire logic ready_pin_i
);
    localparam int CW = ebcs_pkg::CFG_W;
    localparam int AW = ebcs_pkg::ADDR_W;
    localparam int DW = ebcs_pkg::DATA_W;
    localparam int NC = ebcs_pkg::NUM_CS;
    default clocking ebcs_cb @(posedge clk_i); endclocking
    default disable iff (reset_i);  // Checks stay quiet while in reset

    ebcs_pkg::ebcs_state_t state_reg, state_next;
    logic [5:0] cnt_reg, cnt_next;
    logic wr_reg, wr_next, up_reg, up_next, mux_reg, mux_next;
    logic rdy_en_reg, rdy_en_next;
    logic [ebcs_pkg::CS_W-1:0] cs_reg, cs_next;
    logic [AW-1:0] addr_reg, addr_next;
    logic [DW-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next, first_reg, first_next;
    logic [CW-1:0] cfg_reg, cfg_next;
    logic [CW-1:0] cfg_sel;
    logic [CW-1:0] cfg_arr [NC];
    logic ready_ok, window_chg;
    logic [NC-1:0] cs_dec;

    // Split the flat configuration into per-chip-select words
    genvar g;
    generate
        for (g = 0; g < NC; g++) begin : g_cfg
            assign cfg_arr[g] = chip_select_timing_config_i[g*CW +: CW];
            assign cs_dec[g] = (int'(cs_reg) == g);
        end
    endgenerate
    assign cfg_sel = cfg_arr[req_cs_i];

    ebcs_ready_sync u_ready (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ready_active_high_i(ready_active_high_i),
        .ready_async_i(ready_async_i),
        .ready_pin_i(ready_pin_i),
        .ready_o(ready_ok)
    );

    // Window change: new chip select or first access after reset
    assign window_chg = first_reg || (req_cs_i != cs_reg);

    // Phase lengths as six-bit counts
    function automatic logic [5:0] len_c(input logic [CW-1:0] c);
        len_c = {4'h0, c[ebcs_pkg::C_POS +: 2]};
    endfunction
    function automatic logic [5:0] len_d(input logic [CW-1:0] c);
        len_d = {5'h00, c[ebcs_pkg::D_POS]};
    endfunction
    function automatic logic [5:0] len_e(input logic [CW-1:0] c);
        len_e = {1'b0, c[ebcs_pkg::E_POS +: 5]} + ebcs_pkg::ONE_CYCLE;
    endfunction
    function automatic logic [5:0] len_f(input logic [CW-1:0] c);
        len_f = {4'h0, c[ebcs_pkg::F_POS +: 2]};
    endfunction

    // Sequencer next state; zero-length phases are skipped
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        wr_next = wr_reg;
        up_next = up_reg;
        mux_next = mux_reg;
        rdy_en_next = rdy_en_reg;
        cs_next = cs_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        first_next = first_reg;
        cfg_next = cfg_reg;
        case (state_reg)
            ebcs_pkg::EBCS_IDLE: begin
                if (req_valid_i) begin
                    cfg_next = cfg_sel;
                    wr_next = req_write_i;
                    up_next = req_upper_i;
                    cs_next = req_cs_i;
                    addr_next = req_addr_i;
                    wdata_next = req_wdata_i;
                    mux_next = multiplexed_bus_mode_i;
                    rdy_en_next = ready_enable_i[req_cs_i];
                    first_next = 1'b0;
                    state_next = ebcs_pkg::EBCS_ADDR;
                    // 1..2 cycles, up to 3 more on window change
                    cnt_next = {5'h00, cfg_sel[ebcs_pkg::AB_POS]}
                        + ebcs_pkg::ONE_CYCLE
                        + (window_chg ?
                           {4'h0, cfg_sel[ebcs_pkg::WX_POS +: 2]} :
                           ebcs_pkg::ZERO_CYCLE);
                end
            end
            ebcs_pkg::EBCS_ADDR: begin
                if (cnt_reg > ebcs_pkg::ONE_CYCLE) begin
                    cnt_next = cnt_reg - ebcs_pkg::ONE_CYCLE;
                end else if (len_c(cfg_reg) != ebcs_pkg::ZERO_CYCLE) begin
                    state_next = ebcs_pkg::EBCS_CMD;
                    cnt_next = len_c(cfg_reg);
                end else if (len_d(cfg_reg) != ebcs_pkg::ZERO_CYCLE) begin
                    state_next = ebcs_pkg::EBCS_DSET;
                    cnt_next = ebcs_pkg::ONE_CYCLE;
                end else begin
                    state_next = ebcs_pkg::EBCS_ACC;
                    cnt_next = len_e(cfg_reg);
                end
            end
            ebcs_pkg::EBCS_CMD: begin
                if (cnt_reg > ebcs_pkg::ONE_CYCLE) begin
                    cnt_next = cnt_reg - ebcs_pkg::ONE_CYCLE;
                end else if (len_d(cfg_reg) != ebcs_pkg::ZERO_CYCLE) begin
                    state_next = ebcs_pkg::EBCS_DSET;
                    cnt_next = ebcs_pkg::ONE_CYCLE;
                end else begin
                    state_next = ebcs_pkg::EBCS_ACC;
                    cnt_next = len_e(cfg_reg);
                end
            end
            ebcs_pkg::EBCS_DSET: begin
                state_next = ebcs_pkg::EBCS_ACC;
                cnt_next = len_e(cfg_reg);
            end
            ebcs_pkg::EBCS_ACC: begin
                // Programmed count is the minimum; ready then ends it
                if (cnt_reg > ebcs_pkg::ONE_CYCLE) begin
                    cnt_next = cnt_reg - ebcs_pkg::ONE_CYCLE;
                end else if (!rdy_en_reg || ready_ok) begin
                    // Capture on the edge that lifts the read strobe
                    if (!wr_reg) begin
                        rdata_next = mux_reg ? shared_addr_data_bus_i
                                             : separate_bus_mode_data_bus_i;
                        rvalid_next = 1'b1;
                    end
                    if (len_f(cfg_reg) != ebcs_pkg::ZERO_CYCLE) begin
                        state_next = ebcs_pkg::EBCS_HOLD;
                        cnt_next = len_f(cfg_reg);
                    end else begin
                        state_next = ebcs_pkg::EBCS_IDLE;
                    end
                end
            end
            ebcs_pkg::EBCS_HOLD: begin
                if (cnt_reg > ebcs_pkg::ONE_CYCLE) begin
                    cnt_next = cnt_reg - ebcs_pkg::ONE_CYCLE;
                end else begin
                    state_next = ebcs_pkg::EBCS_IDLE;
                end
            end
            default: state_next = ebcs_pkg::EBCS_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= ebcs_pkg::EBCS_IDLE;
            cnt_reg <= ebcs_pkg::ZERO_CYCLE;
            wr_reg <= 1'b0;
            up_reg <= 1'b0;
            mux_reg <= 1'b0;
            rdy_en_reg <= 1'b0;
            cs_reg <= '0;
            addr_reg <= '0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
            first_reg <= 1'b1;
            cfg_reg <= ebcs_pkg::CFG_RESET;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            wr_reg <= wr_next;
            up_reg <= up_next;
            mux_reg <= mux_next;
            rdy_en_reg <= rdy_en_next;
            cs_reg <= cs_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            first_reg <= first_next;
            cfg_reg <= cfg_next;
        end
    end

    // Pin drive; the address register holds through the strobe end
    logic active, strobe, drive_w;
    assign active = (state_reg != ebcs_pkg::EBCS_IDLE);
    assign strobe = (state_reg == ebcs_pkg::EBCS_ACC);
    assign drive_w = wr_reg && (state_reg == ebcs_pkg::EBCS_DSET ||
        state_reg == ebcs_pkg::EBCS_ACC || state_reg == ebcs_pkg::EBCS_HOLD);
    assign req_ready_o = (state_reg == ebcs_pkg::EBCS_IDLE);
    assign busy_o = active;
    assign rdata_o = rdata_reg;
    assign rdata_valid_o = rvalid_reg;
    assign separate_bus_mode_addr_bus_o = addr_reg;
    assign separate_bus_mode_data_bus_o = wdata_reg;
    assign separate_bus_mode_data_bus_oe_n_o = !(drive_w && !mux_reg);
    // Mux: address during setup, write data afterwards
    assign shared_addr_data_bus_o =
        (state_reg == ebcs_pkg::EBCS_ADDR) ? addr_reg[DW-1:0] : wdata_reg;
    assign shared_addr_data_bus_oe_n_o = !(mux_reg &&
        ((state_reg == ebcs_pkg::EBCS_ADDR) || drive_w));
    assign addr_latch_o = (state_reg == ebcs_pkg::EBCS_ADDR);
    assign read_n_o = !(strobe && !wr_reg);
    assign write_n_o = !(strobe && wr_reg);
    assign upper_byte_enable_n_o = !(active && up_reg);
    assign chip_select_n_o = active ? ~cs_dec : {NC{1'b1}};

    // Checks
    int unsigned acc_cnt;
    always_ff @(posedge clk_i) begin
        if (reset_i || !strobe) acc_cnt <= 0;
        else acc_cnt <= acc_cnt + 1;
    end

    sequence s_acc_end;
        strobe ##1 !strobe;
    endsequence
    a_order_fixed: assert property (
        state_reg == ebcs_pkg::EBCS_ACC && state_next != state_reg |->
        state_next inside {ebcs_pkg::EBCS_HOLD, ebcs_pkg::EBCS_IDLE})
        else $error("access left to wrong phase");
    a_dset_one: assert property (
        state_reg == ebcs_pkg::EBCS_DSET |=> state_reg != ebcs_pkg::EBCS_DSET)
        else $error("data setup longer than one cycle");
    a_acc_min: assert property (
        $fell(strobe) |-> $past(acc_cnt) >= len_e(cfg_reg) - 1)
        else $error("access phase too short");
    a_acc_fixed: assert property (
        strobe && !rdy_en_reg |-> acc_cnt < 32)
        else $error("access phase above 32 cycles");
    a_read_capture: assert property (
        (strobe && !wr_reg) ##1 !strobe |-> rdata_valid_o)
        else $error("read data not captured at strobe end");
    a_ready_wait: assert property (
        strobe && rdy_en_reg && cnt_reg <= 1 && !ready_ok |=> strobe)
        else $error("ended without ready");
    a_addr_stable: assert property (
        strobe |=> $stable(separate_bus_mode_addr_bus_o))
        else $error("address moved during access");
    a_idle_after: assert property (
        s_acc_end |-> !strobe ##0 (state_reg != ebcs_pkg::EBCS_ADDR))
        else $error("new access before hold finished");
endmodule
`default_nettype wire

// file: test/ebcs_ext_mem.sv
// Behavioural external memory with a ready handshake, seen from the pins
`default_nettype none
module ebcs_ext_mem (
    // Clock
    input wire logic clk_i,
    // Bus driven by the sequencer
    input wire logic mux_i,
    input wire logic [23:0] addr_i,
    input wire logic [15:0] data_i,
    input wire logic [15:0] shared_i,
    input wire logic addr_latch_i,
    input wire logic read_n_i,
    input wire logic write_n_i,
    input wire logic [3:0] cs_n_i,
    // Ready behaviour chosen by the bench
    input wire logic ready_high_i,
    input wire logic [3:0] ready_wait_i,
    // Bus back to the sequencer
    output logic [15:0] rdata_o,
    output logic ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [256];
    logic [7:0] a_reg = 8'h00;
    logic [15:0] last_reg = 16'hA5A5;
    logic [3:0] cnt_reg = 4'h0;
    logic sel;
    logic strobe;
    assign sel = (cs_n_i != 4'hF);
    assign strobe = sel && !(read_n_i && write_n_i);
    // Address taken only while latched, so later address moves do no harm
    always @(posedge clk_i) begin
        if (addr_latch_i)
            a_reg <= mux_i ? shared_i[7:0] : addr_i[7:0];
        if (sel && !write_n_i) mem[a_reg] <= mux_i ? shared_i : data_i;
        cnt_reg <= strobe ? cnt_reg + 4'h1 : 4'h0;
        last_reg <= rdata_o;
    end
    // Data held while read strobe is low; a changing pattern afterwards
    assign rdata_o = (sel && !read_n_i) ? mem[a_reg] : ~last_reg;
    // Ready turns active after the chosen number of strobe cycles
    assign ready_o = (strobe && cnt_reg >= ready_wait_i)
        == ready_high_i;
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the external bus cycle sequencer
`default_nettype none
`define CHECK(name, exp, got) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("FAIL %s expected %0h seen %0h", name, exp, got); \
    end \
end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [51:0] cfg;
    logic multiplexed_bus_mode = 1'b0;
    logic rdy_hi = 1'b1;
    logic rdy_async = 1'b0;
    logic [3:0] rdy_en = 4'h4;
    logic [3:0] rdy_wait = 4'h0;
    logic valid = 1'b0;
    logic wr = 1'b0;
    logic upper = 1'b0;
    logic [1:0] cs = 2'h0;
    logic [23:0] addr = 24'h00_0000;
    logic [15:0] wdata = 16'h0000;
    logic req_ready, rdata_valid, busy, doe_n, soe_n, ale, rd_n, wr_n;
    logic ube_n, rdy;
    logic [15:0] rdata, dout, sout, din;
    logic [23:0] aout;
    logic [3:0] cs_n;
    logic [15:0] shadow [256];
    int ab_t[4] = '{1, 2, 1, 2};
    int c_t[4] = '{0, 3, 1, 1};
    int d_t[4] = '{0, 1, 0, 1};
    int e_t[4] = '{1, 32, 2, 3};
    int f_t[4] = '{0, 3, 1, 2};
    int wx_t[4] = '{0, 3, 1, 2};
    int fail_count = 0;
    int check_count = 0;
    int n_busy, n_ale, n_strb;
    logic first = 1'b1;
    logic [1:0] prev_cs = 2'h0;
    logic [15:0] got;

    ebcs_sequencer i_ebcs_sequencer (.clk_i(clk), .reset_i(reset),
        .chip_select_timing_config_i(cfg), .multiplexed_bus_mode_i(multiplexed_bus_mode),
        .ready_enable_i(rdy_en), .ready_active_high_i(rdy_hi),
        .ready_async_i(rdy_async), .req_valid_i(valid),
        .req_ready_o(req_ready), .req_write_i(wr), .req_cs_i(cs),
        .req_addr_i(addr), .req_wdata_i(wdata), .req_upper_i(upper),
        .rdata_valid_o(rdata_valid), .rdata_o(rdata), .busy_o(busy),
        .separate_bus_mode_addr_bus_o(aout), .separate_bus_mode_data_bus_i(din),
        .separate_bus_mode_data_bus_o(dout), .separate_bus_mode_data_bus_oe_n_o(doe_n),
        .shared_addr_data_bus_i(din), .shared_addr_data_bus_o(sout),
        .shared_addr_data_bus_oe_n_o(soe_n), .addr_latch_o(ale),
        .read_n_o(rd_n), .write_n_o(wr_n), .upper_byte_enable_n_o(ube_n),
        .chip_select_n_o(cs_n), .ready_pin_i(rdy));
    ebcs_ext_mem i_ebcs_ext_mem (.clk_i(clk), .mux_i(multiplexed_bus_mode), .addr_i(aout),
        .data_i(dout), .shared_i(sout), .addr_latch_i(ale), .read_n_i(rd_n),
        .write_n_i(wr_n), .cs_n_i(cs_n), .ready_high_i(rdy_hi),
        .ready_wait_i(rdy_wait), .rdata_o(din), .ready_o(rdy));

    // Clock at 10 MHz
    always #50 clk = ~clk;

    // One access: request, watch the pins each cycle, judge the phases
    task automatic access(input logic w, input logic [1:0] c,
                          input logic [23:0] a, input logic [15:0] d,
                          input logic u);
        int x, tot;
        x = (first || c != prev_cs) ? wx_t[c] : 0;
        tot = ab_t[c] + x + c_t[c] + d_t[c] + e_t[c] + f_t[c];
        @(posedge clk);
        valid <= 1'b1;
        wr <= w;
        cs <= c;
        addr <= a;
        wdata <= d;
        upper <= u;
        @(posedge clk);
        while (req_ready !== 1'b1) @(posedge clk);
        valid <= 1'b0;
        n_busy = 0;
        n_ale = 0;
        n_strb = 0;
        got = 16'hxxxx;
        repeat (200) begin
            @(negedge clk);
            if (rdata_valid === 1'b1) got = rdata;
            if (busy !== 1'b1) break;
            n_busy++;
            if (ale === 1'b1) n_ale++;
            if (ale === 1'b1 && multiplexed_bus_mode) `CHECK("mux addr", a[15:0], sout)
            if ((w ? wr_n : rd_n) === 1'b0) begin
                n_strb++;
                `CHECK("byte enable", !u, ube_n)
                `CHECK("chip select", ~(4'h1 << c), cs_n)
                if (!multiplexed_bus_mode) `CHECK("addr bus", a, aout)
                if (w && !multiplexed_bus_mode)
                    `CHECK("separate_bus_mode wdata", {d, 1'b0}, {dout, doe_n})
                if (w && multiplexed_bus_mode)
                    `CHECK("mux wdata", {d, 1'b0}, {sout, soe_n})
            end
        end
        `CHECK("addr phase", ab_t[c] + x, n_ale)
        if (!rdy_en[c]) begin
            `CHECK("strobe len", e_t[c], n_strb)
            `CHECK("cycle len", tot, n_busy)
        end
        if (w) shadow[a[7:0]] = d;
        else `CHECK("read data", shadow[a[7:0]], got)
        prev_cs = c;
        first = 1'b0;
    endtask

    // Idle pin levels straight after reset
    task automatic t_reset();
        `CHECK("idle pins", 8'hFF, {rd_n, wr_n, cs_n, doe_n, soe_n})
        `CHECK("idle busy", 1'b0, busy)
    endtask

    // Separate buses: widest timing, then the shortest, back to back
    task automatic t_separate_bus_mode();
        access(1'b1, 2'h1, 24'hAB_CD12, 16'h1234, 1'b1);
        access(1'b0, 2'h1, 24'hAB_CD12, 16'h0000, 1'b0);
        access(1'b1, 2'h0, 24'h00_0034, 16'hBEEF, 1'b0);
        access(1'b0, 2'h0, 24'h00_0034, 16'h0000, 1'b1);
        access(1'b0, 2'h1, 24'hAB_CD12, 16'h0000, 1'b1);
    endtask

    // Shared lines carry address, then write data
    task automatic t_mux();
        @(posedge clk);
        multiplexed_bus_mode <= 1'b1;
        access(1'b1, 2'h3, 24'h00_5A77, 16'hC3C3, 1'b0);
        access(1'b0, 2'h3, 24'h00_5A77, 16'h0000, 1'b1);
        @(posedge clk);
        multiplexed_bus_mode <= 1'b0;
    endtask

    // Ready stretches access; the synchroniser costs at least a cycle
    task automatic t_ready();
        int len[2];
        access(1'b1, 2'h0, 24'h00_0077, 16'h7E57, 1'b0);
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 2; s++) begin
                @(posedge clk);
                rdy_hi <= p[0];
                rdy_async <= s[0];
                rdy_wait <= 4'h3;
                access(1'b0, 2'h2, 24'h00_0077, 16'h0000, 1'b0);
                len[s] = n_strb;
                `CHECK("ready wait", 1'b1, n_strb > e_t[2])
            end
            `CHECK("async cost", 1'b1, len[1] >= len[0] + 1)
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Configuration words built from the phase tables above
    initial begin
        for (int i = 0; i < 4; i++) begin
            cfg[i*13 +: 13] = {2'(wx_t[i]), 2'(f_t[i]), 5'(e_t[i] - 1),
                               1'(d_t[i]), 2'(c_t[i]), 1'(ab_t[i] - 1)};
        end
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        t_reset();
        t_separate_bus_mode();
        t_mux();
        t_ready();
        give_verdict();
    end

    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        #500000;
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
